// File: hw/ioxr_pkg.sv
package ioxr_pkg;

	// build options selecting power-up defaults
	localparam logic [1:0] BUILD_STD      = 2'h0;
	localparam logic [1:0] BUILD_ZERO_OUT = 2'h1;
	localparam logic [1:0] BUILD_INV_PULL = 2'h2;

	// bus addressing
	localparam logic [6:0] TARGET_ADDR_BASE = 7'h20;
	localparam logic [7:0] GCALL_ADDR_BYTE  = 8'h00;
	localparam logic [7:0] SRST_DATA_BYTE   = 8'h06;
	localparam int         EXTENDED_SELECT_BIT = 6;
	localparam logic [7:0] PTR_RESET        = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

	// register offsets (pointer values)
	localparam logic [7:0] OFF_INPUT_LEVEL_0      = 8'h00;
	localparam logic [7:0] OFF_INPUT_LEVEL_1      = 8'h01;
	localparam logic [7:0] OFF_OUTPUT_LEVEL_0     = 8'h02;
	localparam logic [7:0] OFF_OUTPUT_LEVEL_1     = 8'h03;
	localparam logic [7:0] OFF_INVERT_0           = 8'h04;
	localparam logic [7:0] OFF_INVERT_1           = 8'h05;
	localparam logic [7:0] OFF_DIRECTION_0        = 8'h06;
	localparam logic [7:0] OFF_DIRECTION_1        = 8'h07;
	localparam logic [7:0] OFF_DRIVE_LEVEL_0_LOW  = 8'h40;
	localparam logic [7:0] OFF_DRIVE_LEVEL_0_HIGH = 8'h41;
	localparam logic [7:0] OFF_DRIVE_LEVEL_1_LOW  = 8'h42;
	localparam logic [7:0] OFF_DRIVE_LEVEL_1_HIGH = 8'h43;
	localparam logic [7:0] OFF_LATCH_ENABLE_0     = 8'h44;
	localparam logic [7:0] OFF_LATCH_ENABLE_1     = 8'h45;
	localparam logic [7:0] OFF_BIAS_ENABLE_0      = 8'h46;
	localparam logic [7:0] OFF_BIAS_ENABLE_1      = 8'h47;
	localparam logic [7:0] OFF_BIAS_SELECT_0      = 8'h48;
	localparam logic [7:0] OFF_BIAS_SELECT_1      = 8'h49;
	localparam logic [7:0] OFF_EVENT_MASK_0       = 8'h4a;
	localparam logic [7:0] OFF_EVENT_MASK_1       = 8'h4b;
	localparam logic [7:0] OFF_EVENT_FLAGS_0      = 8'h4c;
	localparam logic [7:0] OFF_EVENT_FLAGS_1      = 8'h4d;
	localparam logic [7:0] OFF_OUTPUT_MODE_CONFIG = 8'h4f;
	localparam logic [7:0] OFF_EXT_UNUSED         = 8'h4e;

	// reset values
	localparam logic [7:0] RST_ONES  = 8'hff;
	localparam logic [7:0] RST_ZEROS = 8'h00;

	// synchroniser vector layout: pins, strap, sda, scl
	localparam int        SYNC_W      = 19;
	localparam int        SYNC_STRAP  = 16;
	localparam int        SYNC_SDA    = 17;
	localparam int        SYNC_SCL    = 18;
	localparam logic [18:0] SYNC_RESET = 19'h60000;

	// bus target states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_ACK  = 6'h04,
		ST_RX   = 6'h08,
		ST_TX   = 6'h10,
		ST_MACK = 6'h20
	} ioxr_state_t;

	// configuration outputs toward the port logic
	typedef struct packed {
		logic [15:0] invert;
		logic [31:0] drive_level;
		logic [15:0] latch_enable;
		logic [15:0] bias_enable;
		logic [15:0] bias_select;
		logic [15:0] event_mask;
		logic [7:0]  output_mode;
	} ioxr_cfg_t;

	// filtered view of the bus pins
	typedef struct packed {
		logic scl;
		logic sda;
	} ioxr_bus_t;

endpackage : ioxr_pkg

// File: hw/ioxr_top.sv
`timescale 1ns/1ps

// How it works
// - strap low answers 0x20, high 0x21
// - address lsb one reads, zero writes
// - first byte after write address sets pointer
// - pointer decode uses bit six plus low nibble
// - read transfers never take a pointer byte
// - pointer holds across reads until rewritten
// - pointer clears on any reset
// - standard build power-up defaults
// - option zeroes output and direction defaults
// - option sets invert, bias enable; clears mask
// - 0x44/0x45 latch enables, reset zero
// - 0x4f output mode register, reset zero
// - input reads show present pin levels, inverted where invert and direction bits are set
// - input register writes acked, no effect
// - input registers have no reset value
// - general call 0x06 then stop resets all
// - reset pin holds registers and bus logic
// - output register reads return flip-flops
// - direction one is input, zero drives
module ioxr_top #(
	parameter logic [1:0] BUILD = ioxr_pkg::BUILD_STD
) (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             clk_en_i,
	input  wire logic             scl_i,
	input  wire logic             sda_i,
	output logic                  sda_o,
	output logic                  sda_oe_o,
	input  wire logic             addr_strap_i,
	input  wire logic [15:0]      port_pin_i,
	output logic [15:0]           port_out_o,
	output logic [15:0]           port_oe_o,
	input  wire logic [15:0]      event_flags_i,
	output ioxr_pkg::ioxr_cfg_t   cfg_o
);

	// compact register index: extended select bit above the low nibble
	function automatic logic [4:0] reg_idx(input logic [7:0] ptr);
		reg_idx = {ptr[ioxr_pkg::EXTENDED_SELECT_BIT], ptr[3:0]};
	endfunction : reg_idx

	// basic bank holds eight registers, extended bank all but one slot
	function automatic logic is_mapped(input logic [4:0] idx);
		if (idx[4])
			is_mapped = (idx != reg_idx(ioxr_pkg::OFF_EXT_UNUSED));
		else
			is_mapped = ~idx[3];
	endfunction : is_mapped

	// input levels and event flags are read-only views
	function automatic logic is_writable(input logic [4:0] idx);
		is_writable = is_mapped(idx)
			&& (idx != reg_idx(ioxr_pkg::OFF_INPUT_LEVEL_0))
			&& (idx != reg_idx(ioxr_pkg::OFF_INPUT_LEVEL_1))
			&& (idx != reg_idx(ioxr_pkg::OFF_EVENT_FLAGS_0))
			&& (idx != reg_idx(ioxr_pkg::OFF_EVENT_FLAGS_1));
	endfunction : is_writable

	// power-up value of each slot for the selected build
	function automatic logic [7:0] rst_val(input logic [4:0] idx);
		logic [7:0] v;
		v = ioxr_pkg::RST_ZEROS;
		if (idx == reg_idx(ioxr_pkg::OFF_OUTPUT_LEVEL_0) || idx == reg_idx(ioxr_pkg::OFF_OUTPUT_LEVEL_1)
			|| idx == reg_idx(ioxr_pkg::OFF_DIRECTION_0) || idx == reg_idx(ioxr_pkg::OFF_DIRECTION_1))
			v = (BUILD == ioxr_pkg::BUILD_ZERO_OUT) ? ioxr_pkg::RST_ZEROS : ioxr_pkg::RST_ONES;
		else if (idx == reg_idx(ioxr_pkg::OFF_INVERT_0) || idx == reg_idx(ioxr_pkg::OFF_INVERT_1)
			|| idx == reg_idx(ioxr_pkg::OFF_BIAS_ENABLE_0) || idx == reg_idx(ioxr_pkg::OFF_BIAS_ENABLE_1))
			v = (BUILD == ioxr_pkg::BUILD_INV_PULL) ? ioxr_pkg::RST_ONES : ioxr_pkg::RST_ZEROS;
		else if (idx == reg_idx(ioxr_pkg::OFF_EVENT_MASK_0) || idx == reg_idx(ioxr_pkg::OFF_EVENT_MASK_1))
			v = (BUILD == ioxr_pkg::BUILD_INV_PULL) ? ioxr_pkg::RST_ZEROS : ioxr_pkg::RST_ONES;
		else if (idx == reg_idx(ioxr_pkg::OFF_DRIVE_LEVEL_0_LOW) || idx == reg_idx(ioxr_pkg::OFF_DRIVE_LEVEL_0_HIGH)
			|| idx == reg_idx(ioxr_pkg::OFF_DRIVE_LEVEL_1_LOW) || idx == reg_idx(ioxr_pkg::OFF_DRIVE_LEVEL_1_HIGH)
			|| idx == reg_idx(ioxr_pkg::OFF_BIAS_SELECT_0) || idx == reg_idx(ioxr_pkg::OFF_BIAS_SELECT_1))
			v = ioxr_pkg::RST_ONES;
		// latch enables and output mode stay zero in every build
		rst_val = v;
	endfunction : rst_val

	// synchroniser group: three stages, filtered value moves when stages two and three agree
	logic [ioxr_pkg::SYNC_W-1:0] sync1_r;
	logic [ioxr_pkg::SYNC_W-1:0] sync2_r;
	logic [ioxr_pkg::SYNC_W-1:0] sync3_r;
	logic [ioxr_pkg::SYNC_W-1:0] filt_r;
	logic [ioxr_pkg::SYNC_W-1:0] filt_nxt;

	genvar g;
	generate
		for (g = 0; g < ioxr_pkg::SYNC_W; g++)
		begin : g_filt
			// a one-cycle glitch between stages never reaches the filtered level
			always_comb
			begin
				filt_nxt[g] = (sync2_r[g] == sync3_r[g]) ? sync3_r[g] : filt_r[g];
			end
		end
	endgenerate

	// register the synchroniser stages
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sync1_r <= ioxr_pkg::SYNC_RESET;
			sync2_r <= ioxr_pkg::SYNC_RESET;
			sync3_r <= ioxr_pkg::SYNC_RESET;
			filt_r  <= ioxr_pkg::SYNC_RESET;
		end
		else if (clk_en_i)
		begin
			sync1_r <= {scl_i, sda_i, addr_strap_i, port_pin_i};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_r  <= filt_nxt;
		end
	end

	ioxr_pkg::ioxr_bus_t bus_f;
	ioxr_pkg::ioxr_bus_t bus_q;
	logic [15:0]         pin_lvl;
	logic [6:0]          own_addr;

	assign bus_f    = '{scl: filt_r[ioxr_pkg::SYNC_SCL], sda: filt_r[ioxr_pkg::SYNC_SDA]};
	assign pin_lvl  = filt_r[15:0];
	assign own_addr = {ioxr_pkg::TARGET_ADDR_BASE[6:1], filt_r[ioxr_pkg::SYNC_STRAP]};

	// bus target and register bank state
	ioxr_pkg::ioxr_state_t state_r;
	ioxr_pkg::ioxr_state_t state_nxt;
	logic [3:0]            cnt_r;
	logic [3:0]            cnt_nxt;
	logic [7:0]            shift_r;
	logic [7:0]            shift_nxt;
	logic [7:0]            ptr_r;
	logic [7:0]            ptr_nxt;
	logic                  rd_mode_r;
	logic                  rd_mode_nxt;
	logic                  first_r;
	logic                  first_nxt;
	logic                  gcall_r;
	logic                  gcall_nxt;
	logic                  srst_arm_r;
	logic                  srst_arm_nxt;
	logic                  drv_r;
	logic                  drv_nxt;
	logic [7:0]            regs_r   [32];
	logic [7:0]            regs_nxt [32];

	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic [4:0] cur_idx;
	logic [7:0] rd_data;
	logic [15:0] in_level;

	assign scl_rise  = bus_f.scl & ~bus_q.scl;
	assign scl_fall  = ~bus_f.scl & bus_q.scl;
	assign start_det = bus_f.scl & bus_q.scl & bus_q.sda & ~bus_f.sda;
	assign stop_det  = bus_f.scl & bus_q.scl & ~bus_q.sda & bus_f.sda;
	assign cur_idx   = reg_idx(ptr_r);

	// inversion only touches pins configured as inputs; outputs still read their true level
	assign in_level = pin_lvl ^ ({regs_r[reg_idx(ioxr_pkg::OFF_INVERT_1)], regs_r[reg_idx(ioxr_pkg::OFF_INVERT_0)]}
		& {regs_r[reg_idx(ioxr_pkg::OFF_DIRECTION_1)], regs_r[reg_idx(ioxr_pkg::OFF_DIRECTION_0)]});

	// read mux: live views for inputs and flags, zero for unmapped slots, stored bytes otherwise
	always_comb
	begin
		if (!is_mapped(cur_idx))
			rd_data = ioxr_pkg::RST_ZEROS;
		else if (cur_idx == reg_idx(ioxr_pkg::OFF_INPUT_LEVEL_0))
			rd_data = in_level[7:0];
		else if (cur_idx == reg_idx(ioxr_pkg::OFF_INPUT_LEVEL_1))
			rd_data = in_level[15:8];
		else if (cur_idx == reg_idx(ioxr_pkg::OFF_EVENT_FLAGS_0))
			rd_data = event_flags_i[7:0];
		else if (cur_idx == reg_idx(ioxr_pkg::OFF_EVENT_FLAGS_1))
			rd_data = event_flags_i[15:8];
		else
			rd_data = regs_r[cur_idx];
	end

	// next-state logic of the target and its registers
	always_comb
	begin
		state_nxt    = state_r;
		cnt_nxt      = cnt_r;
		shift_nxt    = shift_r;
		ptr_nxt      = ptr_r;
		rd_mode_nxt  = rd_mode_r;
		first_nxt    = first_r;
		gcall_nxt    = gcall_r;
		srst_arm_nxt = srst_arm_r;
		drv_nxt      = drv_r;
		regs_nxt     = regs_r;
		if (start_det)
		begin
			// a repeated start abandons any armed software reset
			state_nxt    = ioxr_pkg::ST_ADDR;
			cnt_nxt      = 4'h0;
			gcall_nxt    = 1'b0;
			srst_arm_nxt = 1'b0;
			drv_nxt      = 1'b0;
		end
		else if (stop_det)
		begin
			state_nxt    = ioxr_pkg::ST_IDLE;
			drv_nxt      = 1'b0;
			gcall_nxt    = 1'b0;
			srst_arm_nxt = 1'b0;
			if (srst_arm_r)
			begin
				for (int i = 0; i < 32; i++)
					regs_nxt[i] = rst_val(5'(i));
				ptr_nxt = ioxr_pkg::PTR_RESET;
			end
		end
		else
		begin
			case (state_r)
				ioxr_pkg::ST_IDLE:
				begin
					drv_nxt = 1'b0;
				end
				ioxr_pkg::ST_ADDR:
				begin
					if (scl_rise)
					begin
						shift_nxt = {shift_r[6:0], bus_f.sda};
						cnt_nxt   = cnt_r + 4'h1;
					end
					else if (scl_fall && cnt_r == ioxr_pkg::BITS_PER_BYTE)
					begin
						if (shift_r[7:1] == own_addr)
						begin
							drv_nxt     = 1'b1;
							rd_mode_nxt = shift_r[0];
							first_nxt   = ~shift_r[0];
							state_nxt   = ioxr_pkg::ST_ACK;
						end
						else if (shift_r == ioxr_pkg::GCALL_ADDR_BYTE)
						begin
							// general call write only; a read form is never acknowledged
							drv_nxt     = 1'b1;
							rd_mode_nxt = 1'b0;
							first_nxt   = 1'b1;
							gcall_nxt   = 1'b1;
							state_nxt   = ioxr_pkg::ST_ACK;
						end
						else
							state_nxt = ioxr_pkg::ST_IDLE;
					end
				end
				ioxr_pkg::ST_ACK:
				begin
					// acknowledge clock ends: hand the line to the next byte
					if (scl_fall)
					begin
						cnt_nxt = 4'h0;
						if (rd_mode_r)
						begin
							shift_nxt = rd_data;
							drv_nxt   = ~rd_data[7];
							cnt_nxt   = 4'h1;
							state_nxt = ioxr_pkg::ST_TX;
						end
						else
						begin
							drv_nxt   = 1'b0;
							state_nxt = ioxr_pkg::ST_RX;
						end
					end
				end
				ioxr_pkg::ST_RX:
				begin
					if (scl_rise)
					begin
						shift_nxt = {shift_r[6:0], bus_f.sda};
						cnt_nxt   = cnt_r + 4'h1;
					end
					else if (scl_fall && cnt_r == ioxr_pkg::BITS_PER_BYTE)
					begin
						first_nxt = 1'b0;
						state_nxt = ioxr_pkg::ST_ACK;
						drv_nxt   = 1'b1;
						if (gcall_r)
						begin
							// only a single 0x06 byte arms the reset; anything else is refused
							if (first_r && shift_r == ioxr_pkg::SRST_DATA_BYTE)
								srst_arm_nxt = 1'b1;
							else
							begin
								srst_arm_nxt = 1'b0;
								drv_nxt      = 1'b0;
								state_nxt    = ioxr_pkg::ST_IDLE;
							end
						end
						else if (first_r)
							ptr_nxt = shift_r;
						else if (is_writable(cur_idx))
							regs_nxt[cur_idx] = shift_r;
					end
				end
				ioxr_pkg::ST_TX:
				begin
					if (scl_fall)
					begin
						if (cnt_r == ioxr_pkg::BITS_PER_BYTE)
						begin
							drv_nxt   = 1'b0;
							cnt_nxt   = 4'h0;
							state_nxt = ioxr_pkg::ST_MACK;
						end
						else
						begin
							drv_nxt   = ~shift_r[6];
							shift_nxt = {shift_r[6:0], 1'b0};
							cnt_nxt   = cnt_r + 4'h1;
						end
					end
				end
				ioxr_pkg::ST_MACK:
				begin
					// controller ack sends another byte of the same register, nack ends
					if (scl_rise)
						state_nxt = bus_f.sda ? ioxr_pkg::ST_IDLE : ioxr_pkg::ST_ACK;
				end
				default:
				begin
					state_nxt = ioxr_pkg::ST_IDLE;
					drv_nxt   = 1'b0;
				end
			endcase
		end
	end

	// register target and bank state; the reset pin holds everything at defaults
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			bus_q      <= '{scl: 1'b1, sda: 1'b1};
			state_r    <= ioxr_pkg::ST_IDLE;
			cnt_r      <= 4'h0;
			shift_r    <= 8'h00;
			ptr_r      <= ioxr_pkg::PTR_RESET;
			rd_mode_r  <= 1'b0;
			first_r    <= 1'b0;
			gcall_r    <= 1'b0;
			srst_arm_r <= 1'b0;
			drv_r      <= 1'b0;
			for (int i = 0; i < 32; i++)
				regs_r[i] <= rst_val(5'(i));
		end
		else if (clk_en_i)
		begin
			bus_q      <= bus_f;
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			shift_r    <= shift_nxt;
			ptr_r      <= ptr_nxt;
			rd_mode_r  <= rd_mode_nxt;
			first_r    <= first_nxt;
			gcall_r    <= gcall_nxt;
			srst_arm_r <= srst_arm_nxt;
			drv_r      <= drv_nxt;
			regs_r     <= regs_nxt;
		end
	end

	// open-drain data line: only ever pulled low
	assign sda_o    = 1'b0;
	assign sda_oe_o = drv_r;

	// port drivers follow the stored output and direction bytes
	assign port_out_o = {regs_r[reg_idx(ioxr_pkg::OFF_OUTPUT_LEVEL_1)], regs_r[reg_idx(ioxr_pkg::OFF_OUTPUT_LEVEL_0)]};
	assign port_oe_o  = ~{regs_r[reg_idx(ioxr_pkg::OFF_DIRECTION_1)],
		regs_r[reg_idx(ioxr_pkg::OFF_DIRECTION_0)]};

	// feature settings for the port logic outside this block
	assign cfg_o.invert       = {regs_r[reg_idx(ioxr_pkg::OFF_INVERT_1)], regs_r[reg_idx(ioxr_pkg::OFF_INVERT_0)]};
	assign cfg_o.drive_level  = {regs_r[reg_idx(ioxr_pkg::OFF_DRIVE_LEVEL_1_HIGH)],
		regs_r[reg_idx(ioxr_pkg::OFF_DRIVE_LEVEL_1_LOW)],
		regs_r[reg_idx(ioxr_pkg::OFF_DRIVE_LEVEL_0_HIGH)],
		regs_r[reg_idx(ioxr_pkg::OFF_DRIVE_LEVEL_0_LOW)]};
	assign cfg_o.latch_enable = {regs_r[reg_idx(ioxr_pkg::OFF_LATCH_ENABLE_1)],
		regs_r[reg_idx(ioxr_pkg::OFF_LATCH_ENABLE_0)]};
	assign cfg_o.bias_enable  = {regs_r[reg_idx(ioxr_pkg::OFF_BIAS_ENABLE_1)],
		regs_r[reg_idx(ioxr_pkg::OFF_BIAS_ENABLE_0)]};
	assign cfg_o.bias_select  = {regs_r[reg_idx(ioxr_pkg::OFF_BIAS_SELECT_1)],
		regs_r[reg_idx(ioxr_pkg::OFF_BIAS_SELECT_0)]};
	assign cfg_o.event_mask   = {regs_r[reg_idx(ioxr_pkg::OFF_EVENT_MASK_1)],
		regs_r[reg_idx(ioxr_pkg::OFF_EVENT_MASK_0)]};
	assign cfg_o.output_mode  = regs_r[reg_idx(ioxr_pkg::OFF_OUTPUT_MODE_CONFIG)];

endmodule : ioxr_top

// File: verification/ioxr_top_asserts.sv
`timescale 1ns/1ps

// pin-level checks of the target; power-up values follow the build option
module ioxr_top_asserts #(
	parameter logic [1:0] BUILD = ioxr_pkg::BUILD_STD
) (
	input wire logic                clk_i,
	input wire logic                reset_n_i,
	input wire logic                scl_i,
	input wire logic                sda_i,
	input wire logic                sda_oe_o,
	input wire logic [15:0]         port_out_o,
	input wire logic [15:0]         port_oe_o,
	input wire ioxr_pkg::ioxr_cfg_t cfg_o
);
	localparam logic [15:0]  ZO    = (BUILD == ioxr_pkg::BUILD_ZERO_OUT) ? 16'h0000 : 16'hffff;
	localparam logic [15:0]  INV   = (BUILD == ioxr_pkg::BUILD_INV_PULL) ? 16'hffff : 16'h0000;
	localparam logic [119:0] CFG_D = {INV, 32'hffffffff, 16'h0000, INV, 16'hffff, ~INV, 8'h00};

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// conditions on the raw pins; the device lags them by its filter
	sequence s_start;
		scl_i && $fell(sda_i);
	endsequence
	sequence s_stop;
		scl_i && $rose(sda_i);
	endsequence
	sequence s_quiet;
		!sda_oe_o [*8];
	endsequence

	chk_out_dflt: assert property ($rose(reset_n_i) |-> port_out_o == ZO && port_oe_o == ~ZO)
		else $error("port outputs off their power-up value");
	chk_cfg_dflt: assert property ($rose(reset_n_i) |-> cfg_o == CFG_D)
		else $error("configuration off its power-up value");
	chk_bus_idle: assert property ($rose(reset_n_i) |-> s_quiet)
		else $error("data line pulled right after reset");
	chk_drive_low: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
		else $error("data line pulled while clock high");
	chk_release_low: assert property ($fell(sda_oe_o) |-> !scl_i)
		else $error("data line released while clock high");
	chk_ack_stands: assert property ($rose(sda_oe_o) |=> sda_oe_o [*8])
		else $error("acknowledge or data bit too short");
	chk_addr_quiet: assert property (s_start |=> s_quiet)
		else $error("device drove during address bits");
	chk_stop_quiet: assert property (s_stop |=> s_quiet)
		else $error("device drove after stop");
endmodule : ioxr_top_asserts

bind ioxr_top ioxr_top_asserts #(.BUILD(BUILD)) chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i),
	.sda_i(sda_i), .sda_oe_o(sda_oe_o), .port_out_o(port_out_o), .port_oe_o(port_oe_o), .cfg_o(cfg_o));

// File: verification/ioxr_ctl_model.sv
`timescale 1ns/1ps

// bus controller: scl pushed, sda only pulled low; a bit takes 4*Q clocks
module ioxr_ctl_model #(
	parameter int Q = 7
) (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_pull_o
);
	// bus idle: both lines high
	initial
	begin
		scl_o      = 1'b1;
		sda_pull_o = 1'b0;
	end

	// lines move only on falling clock edges
	task automatic step();
		repeat (Q) @(negedge clk_i);
	endtask : step

	// data set mid-low, held through high, so no false start or stop
	task automatic bit_x(input logic d, output logic s);
		sda_pull_o = ~d;
		step();
		scl_o = 1'b1;
		step();
		s = sda_i;
		step();
		scl_o = 1'b0;
		step();
	endtask : bit_x

	task automatic start();
		sda_pull_o = 1'b0;
		step();
		scl_o = 1'b1;
		step();
		sda_pull_o = 1'b1;
		step();
		scl_o = 1'b0;
		step();
	endtask : start

	task automatic stop();
		sda_pull_o = 1'b1;
		step();
		scl_o = 1'b1;
		step();
		sda_pull_o = 1'b0;
		step();
		step();
	endtask : stop

	// one byte and its acknowledge bit; a sent 1 releases the line
	task automatic xfer(input logic [7:0] b, input logic rel, output logic [7:0] r, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(b[i], r[i]);
		bit_x(rel, s);
		ack = ~s;
	endtask : xfer

	// write: direction bit low, then one or two bytes
	task automatic wr(input logic [6:0] dev, input logic [7:0] b1, input logic [7:0] b2, input int n,
		output logic [2:0] a);
		logic [7:0] r;
		a = 3'h0;
		start();
		xfer({dev, 1'b0}, 1'b1, r, a[2]);
		xfer(b1, 1'b1, r, a[1]);
		if (n > 1)
			xfer(b2, 1'b1, r, a[0]);
		stop();
	endtask : wr

	// read: direction bit high, no pointer byte; second byte refused
	task automatic rd(input logic [6:0] dev, output logic [15:0] d, output logic a);
		logic [7:0] r;
		logic       ack;
		start();
		xfer({dev, 1'b1}, 1'b1, r, a);
		xfer(8'hff, 1'b0, d[15:8], ack);
		xfer(8'hff, 1'b1, d[7:0], ack);
		stop();
	endtask : rd
endmodule : ioxr_ctl_model

// File: verification/test_i2c_io_expander_register_map.sv
`timescale 1ns/1ps

module test_i2c_io_expander_register_map;
	localparam int LIMIT = 90000;
	logic                clk;
	logic                reset_n;
	logic                strap;
	logic [15:0]         pins;
	logic [15:0]         flags;
	logic                scl;
	logic                sda_pull;
	logic                sda_o;
	logic                sda_oe;
	logic [15:0]         port_out;
	logic [15:0]         port_oe;
	ioxr_pkg::ioxr_cfg_t cfg;
	wire  [151:0]        opt_view [2];
	logic [6:0]          dev;
	int                  n_mismatch;
	int                  check_count;
	int                  cyc;

	// sda has a pull-up: low whenever either side pulls
	wire sda_w = (sda_pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
	assign dev = ioxr_pkg::TARGET_ADDR_BASE | {6'h00, strap};

	ioxr_ctl_model ctl_u (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(sda_pull));
	ioxr_top #(.BUILD(ioxr_pkg::BUILD_STD)) dut_u (.clk_i(clk), .reset_n_i(reset_n), .clk_en_i(1'b1),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_strap_i(strap), .port_pin_i(pins),
		.port_out_o(port_out), .port_oe_o(port_oe), .event_flags_i(flags), .cfg_o(cfg));

	// option builds listen only; their data line is left off the wire
	for (genvar g = 0; g < 2; g++)
	begin : g_opt
		ioxr_top #(.BUILD(g == 0 ? ioxr_pkg::BUILD_ZERO_OUT : ioxr_pkg::BUILD_INV_PULL)) dut_o (.clk_i(clk),
			.reset_n_i(reset_n), .clk_en_i(1'b1), .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_o(),
			.addr_strap_i(strap), .port_pin_i(pins), .port_out_o(opt_view[g][151:136]),
			.port_oe_o(opt_view[g][135:120]), .event_flags_i(flags), .cfg_o(opt_view[g][119:0]));
	end

	// power-up {outputs, enables, configuration} of one build
	function automatic logic [151:0] dflt(input logic [1:0] b);
		logic [15:0] zo;
		logic [15:0] inv;
		zo  = (b == ioxr_pkg::BUILD_ZERO_OUT) ? 16'h0000 : 16'hffff;
		inv = (b == ioxr_pkg::BUILD_INV_PULL) ? 16'hffff : 16'h0000;
		return {zo, ~zo, inv, 32'hffffffff, 16'h0000, inv, 16'hffff, ~inv, 8'h00};
	endfunction : dflt

	task automatic chk(input logic [151:0] seen, input logic [151:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] data);
		logic [2:0] a;
		ctl_u.wr(dev, ptr, data, 2, a);
		chk(a, 3'h7);
	endtask : reg_wr

	// no auto-increment, so both bytes of a read match
	task automatic cur_rd(input logic [7:0] exp);
		logic [15:0] d;
		logic        a;
		ctl_u.rd(dev, d, a);
		chk({a, d}, {1'b1, exp, exp});
	endtask : cur_rd

	task automatic reg_rd(input logic [7:0] ptr, input logic [7:0] exp);
		logic [2:0] a;
		ctl_u.wr(dev, ptr, 8'h00, 1, a);
		chk(a[2:1], 2'h3);
		cur_rd(exp);
	endtask : reg_rd

	task automatic t_defaults();
		chk({port_out, port_oe, cfg}, dflt(ioxr_pkg::BUILD_STD));
		chk(opt_view[0], dflt(ioxr_pkg::BUILD_ZERO_OUT));
		chk(opt_view[1], dflt(ioxr_pkg::BUILD_INV_PULL));
		cur_rd(8'h5a);
		$display("defaults done");
	endtask : t_defaults

	task automatic t_outputs();
		reg_wr(8'h02, 8'h55);
		chk(port_out, 16'hff55);
		reg_wr(8'h07, 8'h0f);
		chk(port_oe, 16'hf000);
		reg_rd(8'h02, 8'h55);
		cur_rd(8'h55);
		reg_rd(8'h03, 8'hff);
		$display("outputs done");
	endtask : t_outputs

	task automatic t_inputs();
		pins = 16'h3cc3;
		reg_wr(8'h00, 8'h99);
		reg_rd(8'h00, 8'hc3);
		reg_rd(8'h01, 8'h3c);
		reg_wr(8'h04, 8'h0f);
		reg_rd(8'h00, 8'hcc);
		reg_wr(8'h4d, 8'h00);
		reg_rd(8'h4c, 8'h48);
		reg_rd(8'h4d, 8'h12);
		$display("inputs done");
	endtask : t_inputs

	// 0x04 and 0x44 differ only in the extended select bit
	task automatic t_extended();
		logic [7:0]   p [7] = '{8'h04, 8'h44, 8'h45, 8'h4f, 8'h41, 8'h48, 8'h4b};
		logic [119:0] e = {16'h0092, 32'hffffd7ff, 16'hd3d2, 16'h0000, 16'hffde, 16'hddff, 8'hd9};
		foreach (p[i])
			reg_wr(p[i], p[i] ^ 8'h96);
		foreach (p[i])
			reg_rd(p[i], p[i] ^ 8'h96);
		chk(cfg, e);
		reg_wr(8'h4e, 8'h77);
		reg_rd(8'h4e, 8'h00);
		reg_rd(8'h08, 8'h00);
		chk(cfg, e);
		$display("extended done");
	endtask : t_extended

	task automatic t_address();
		logic [2:0] a;
		strap = 1'b1;
		repeat (6) @(negedge clk);
		ctl_u.wr(7'h20, 8'h02, 8'h00, 2, a);
		chk({a, port_out}, {3'h0, 16'hff55});
		reg_wr(8'h02, 8'h0a);
		chk(port_out, 16'hff0a);
		strap = 1'b0;
		repeat (6) @(negedge clk);
		$display("address done");
	endtask : t_address

	task automatic t_soft_reset();
		logic [2:0]  a;
		logic [15:0] d;
		ctl_u.wr(7'h00, 8'h07, 8'h00, 1, a);
		chk({a[2:1], port_out}, {2'h2, 16'hff0a});
		// read form of the general call is never answered, so the line floats high
		ctl_u.rd(7'h00, d, a[0]);
		chk({a[0], d}, {1'b0, 16'hffff});
		ctl_u.wr(7'h00, 8'h06, 8'h06, 2, a);
		chk({a, port_out}, {3'h6, 16'hff0a});
		ctl_u.wr(7'h00, 8'h06, 8'h00, 1, a);
		chk(a[2:1], 2'h3);
		chk({port_out, port_oe, cfg}, dflt(ioxr_pkg::BUILD_STD));
		cur_rd(8'hc3);
		$display("soft reset done");
	endtask : t_soft_reset

	task automatic t_hw_reset();
		reg_wr(8'h06, 8'h00);
		chk(port_oe, 16'h00ff);
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		chk({port_out, port_oe, cfg}, dflt(ioxr_pkg::BUILD_STD));
		reset_n = 1'b1;
		repeat (6) @(negedge clk);
		cur_rd(8'hc3);
		$display("hardware reset done");
	endtask : t_hw_reset

	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// clock, and a hang guard well past the expected run length
	always #20 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			n_mismatch++;
			close_out();
		end
	end

	// inputs move only on falling edges
	initial
	begin
		clk         = 1'b0;
		reset_n     = 1'b0;
		strap       = 1'b0;
		pins        = 16'ha55a;
		flags       = 16'h1248;
		cyc         = 0;
		n_mismatch  = 0;
		check_count = 0;
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		repeat (6) @(negedge clk);
		t_defaults();
		t_outputs();
		t_inputs();
		t_extended();
		t_address();
		t_soft_reset();
		t_hw_reset();
		close_out();
	end
endmodule : test_i2c_io_expander_register_map
